/* File: verif/sprs_pin_model.sv */
// sprs_pin_model: external serial devices and pads around the routed pins
// assumes the bench gives the far devices' idle levels; a pad the block drives shows its drive
`timescale 1ns/10ps
module sprs_pin_model (
  input  wire logic [11:0] pat,
  input  wire logic [5:0]  p2Out,
  input  wire logic [5:0]  p2Oe,
  input  wire logic [2:0]  pbOut,
  input  wire logic [2:0]  pbOe,
  input  wire logic [1:0]  p9Out,
  input  wire logic [1:0]  p9Oe,
  output      logic [5:0]  p2Pad,
  output      logic [2:0]  pbPad,
  output      logic [1:0]  p9Pad,
  output      logic        p7Pad
);
  // two-wire pins drive 0 when enabled, so an enabled pad is pulled low
  assign p2Pad = (p2Oe & p2Out) | (~p2Oe & pat[5:0]);
  assign pbPad = (pbOe & pbOut) | (~pbOe & pat[8:6]);
  assign p9Pad = (p9Oe & p9Out) | (~p9Oe & pat[10:9]);
  assign p7Pad = pat[11];
endmodule : sprs_pin_model

/* File: verif/tb.sv */
// tb: self-checking bench for the serial pin route select block
// assumes the byte register port and the pin model; one 50 MHz clock
`timescale 1ns/10ps
module tb;
  logic        clk, sys_rst, regWr, regRd, p7Pad, pend;
  logic        rxZ, rxO, sIn, sClk, tDat, tClk, tCap, l6, l7, l15;
  logic [11:0] regAddr, pat;
  logic [10:0] uin;
  logic [7:0]  regWdata, regRdata_ff;
  logic [5:0]  p2Pad, p2Out, p2Oe, p2Ser;
  logic [2:0]  pbPad, pbOut, pbOe, pbSer;
  logic [1:0]  p9Pad, p9Out, p9Oe, act;
  logic [31:0] rnd;
  logic [7:0]  rdQ[$];
  int          num_errors, checked;

  serial_pin_route_select dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regWdata(regWdata), .regRdata_ff(regRdata_ff), .port2In(p2Pad),
    .portbIn(pbPad), .port9In(p9Pad), .port7Bit2In(p7Pad), .txZero(uin[0]), .txOne(uin[1]),
    .syncOut(uin[2]), .syncClkOut(uin[3]), .syncClkOe(uin[4]), .twiDataOe(uin[5]),
    .twiClkOe(uin[6]), .txZeroEvent(uin[7]), .rxZeroEvent(uin[8]), .syncEvent(uin[9]),
    .twiEvent(uin[10]), .port2Out_ff(p2Out), .port2Oe_ff(p2Oe), .port2Serial_ff(p2Ser),
    .portbOut_ff(pbOut), .portbOe_ff(pbOe), .portbSerial_ff(pbSer), .port9Out_ff(p9Out),
    .port9Oe_ff(p9Oe), .rxZero_ff(rxZ), .rxOne_ff(rxO), .syncIn_ff(sIn), .syncClkIn_ff(sClk),
    .twiDataIn_ff(tDat), .twiClkIn_ff(tClk), .timerCapture_ff(tCap), .activeUnits_ff(act),
    .latchSix_ff(l6), .latchSeven_ff(l7), .latchFifteen_ff(l15));

  sprs_pin_model far (.pat(pat), .p2Out(p2Out), .p2Oe(p2Oe), .pbOut(pbOut), .pbOe(pbOe),
    .p9Out(p9Out), .p9Oe(p9Oe), .p2Pad(p2Pad), .pbPad(pbPad), .p9Pad(p9Pad), .p7Pad(p7Pad));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // claimed pins as {port B bits 4-6, port2 bits 0-5}
  function automatic logic [8:0] claim(input logic [1:0] p, input logic g);
    case (p)
      2'h0: return g ? 9'h0D8 : 9'h01B;
      2'h1: return g ? 9'h0F8 : 9'h03B;
      2'h2: return g ? 9'h1D8 : 9'h01F;
      default: return 9'h000;
    endcase
  endfunction : claim

  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    rdQ.push_back(e);
    @(posedge clk);
    regRd <= 1'b0;
  endtask : rd

  task automatic results();
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // read data lands one edge after the strobe; oldest note is compared
  always @(posedge clk) pend <= regRd;
  always @(negedge clk) begin
    if (pend) chk("readData", {1'b0, rdQ.pop_front()}, {1'b0, regRdata_ff});
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end

  initial begin
    logic [1:0] pr, ts;
    logic       g, s0, s1, ax, tw, e6, e15, sx, tsrc, sk;
    {regWr, regRd, regAddr, regWdata, pat, uin} = '0;
    num_errors = 0;
    checked = 0;
    rnd = 32'h7919;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(sprs_pkg::ROUTE_OFFSET, 8'h00);
    rd(sprs_pkg::SWAP_OFFSET, 8'h00);
    wr(sprs_pkg::ROUTE_OFFSET, 8'hFF);
    wr(sprs_pkg::SWAP_OFFSET, 8'hFF);
    wr(12'hF56, 8'hFF);
    rd(sprs_pkg::ROUTE_OFFSET, 8'hD3);
    rd(sprs_pkg::SWAP_OFFSET, 8'h03);
    rd(12'hF56, 8'h00);
    for (int i = 0; i < 128; i++) begin
      rnd = lfsr(rnd);
      {s1, s0, g, pr} = i[4:0];
      ts = i[6:5];
      ax = (pr == 2'h0) || (pr == 2'h1);
      tw = (pr == 2'h0) || (pr == 2'h2);
      @(posedge clk);
      uin <= '0;  // units idle while routing changes
      wr(sprs_pkg::ROUTE_OFFSET, {ts, 1'b0, g, 2'b00, pr});
      wr(sprs_pkg::SWAP_OFFSET, {6'h00, s1, s0});
      rd(sprs_pkg::ROUTE_OFFSET, {ts, 1'b0, g, 2'b00, pr});
      @(negedge clk);
      // quiet units after a change leave no stale event on the shared latches
      chk("latchClear", 9'h000, {6'h0, l6, l7, l15});
      @(posedge clk);
      pat <= rnd[11:0];
      uin <= rnd[22:12];
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("claim", claim(pr, g), {pbSer, p2Ser});
      chk("active", (pr == 2'h3) ? 9'h0 : 9'h3, {7'h0, act});
      e6 = ax ? uin[8] : (pr == 2'h2) & uin[9];
      e15 = tw ? uin[10] : (pr == 2'h1) & uin[9];
      chk("latches", {6'h0, e6, ax & uin[7], e15}, {6'h0, l6, l7, l15});
      chk("rxOne", {8'h0, s1 ? pat[9] : pat[10]}, {8'h0, rxO});
      chk("txOne", {8'h01, uin[1]}, {7'h0, p9Oe[s1], p9Out[s1]});
      tsrc = (ax & !g & s0) ? uin[0] : pat[1];
      if (ts == 2'h0) tsrc = pat[11];
      else if (ts == 2'h2) tsrc = s1 ? uin[1] : pat[10];
      else if (ts == 2'h3) tsrc = 1'b0;
      chk("timer", {8'h0, tsrc}, {8'h0, tCap});
      if (ax) begin
        chk("rxZero", {8'h0, pat[(g ? 6 : 0) + (s0 ? 0 : 1)]}, {8'h0, rxZ});
        if (g) chk("txZero", {8'h01, uin[0]}, {7'h0, pbOe[s0], pbOut[s0]});
        else chk("txZero", {8'h01, uin[0]}, {7'h0, p2Oe[s0], p2Out[s0]});
      end
      if (tw) chk("twoWire", {7'h0, ~uin[5] & pat[3], ~uin[6] & pat[4]}, {7'h0, tDat, tClk});
      sx = (pr == 2'h1) ? pat[4] : pat[g ? 7 : 1];
      sk = (pr == 2'h1) ? pat[5] : pat[g ? 8 : 2];
      if (pr == 2'h1 || pr == 2'h2) begin
        chk("syncIn", {8'h0, sx}, {8'h0, sIn});
        chk("syncClk", {8'h0, uin[4] ? uin[3] : sk}, {8'h0, sClk});
      end
      if (pr == 2'h1) chk("syncOut", {8'h01, uin[2]}, {7'h0, p2Oe[3], p2Out[3]});
      if (pr == 2'h2 && !g) chk("syncOut", {8'h01, uin[2]}, {7'h0, p2Oe[0], p2Out[0]});
      if (pr == 2'h2 && g) chk("syncOut", {8'h01, uin[2]}, {7'h0, pbOe[0], pbOut[0]});
    end
    // second reset in mid-run: outputs idle, registers back to pair 00
    @(posedge clk);
    sys_rst <= 1'b1;
    @(negedge clk);
    chk("resetOut", 9'h00F, {act, l6, l7, l15, rxZ, rxO, tDat, tClk});
    chk("resetClaim", 9'h000, {pbSer, p2Ser});
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(sprs_pkg::ROUTE_OFFSET, 8'h00);
    rd(sprs_pkg::SWAP_OFFSET, 8'h00);
    @(negedge clk);
    chk("claim", claim(2'h0, 1'b0), {pbSer, p2Ser});
    repeat (3) @(posedge clk);
    if (rdQ.size() != 0) num_errors++;
    results();
  end
endmodule : tb

/* File: verilog/serial_pin_route_select.sv */
// serial_pin_route_select: steers serial unit pins, events and timer capture input
// assumes pins arrive asynchronous; unit-side signals are on clk
// Function
// - at most two of the three serial units are active, chosen by the pair field
// - timer field bits 7:6 pick capture source: port7 bit2, port2 bit1 (rx zero pin in group 0 unswapped), port9 bit1 (rx one pin unswapped)
// - group bit 4 puts async zero, and sync zero in pair 10, on port2 bits 0-2 or port B bits 4-6
// - pair field bits 1:0: async+twi, async+sync, sync+twi; 11 reserved
// - latches six, seven, fifteen carry events according to the pair field
// - swap bit 1 exchanges receive and transmit of async one on port 9
// - swap bit 0 exchanges receive and transmit of async zero in its group
// - two-wire on port2 bits 3/4; sync zero on port2 bits 3-5 in pair 01
// - pins not claimed by a serial function stay general port pins
`timescale 1ns/10ps
module serial_pin_route_select (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic [sprs_pkg::ADDR_W-1:0] regAddr,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  input  wire logic [7:0]                  regWdata,
  output      logic [7:0]                  regRdata_ff,
  // pin inputs: port2 bits 0-5, port B bits 4-6, port9 bits 0-1, port7 bit 2
  input  wire logic [5:0]                  port2In,
  input  wire logic [2:0]                  portbIn,
  input  wire logic [1:0]                  port9In,
  input  wire logic                        port7Bit2In,
  // unit side: outputs of the serial units and their enables
  input  wire logic                        txZero,
  input  wire logic                        txOne,
  input  wire logic                        syncOut,
  input  wire logic                        syncClkOut,
  input  wire logic                        syncClkOe,
  input  wire logic                        twiDataOe,
  input  wire logic                        twiClkOe,
  input  wire logic                        txZeroEvent,
  input  wire logic                        rxZeroEvent,
  input  wire logic                        syncEvent,
  input  wire logic                        twiEvent,
  // pin side: serial function drive, enable and claim
  output      logic [5:0]                  port2Out_ff,
  output      logic [5:0]                  port2Oe_ff,
  output      logic [5:0]                  port2Serial_ff,
  output      logic [2:0]                  portbOut_ff,
  output      logic [2:0]                  portbOe_ff,
  output      logic [2:0]                  portbSerial_ff,
  output      logic [1:0]                  port9Out_ff,
  output      logic [1:0]                  port9Oe_ff,
  // unit side outputs
  output      logic                        rxZero_ff,
  output      logic                        rxOne_ff,
  output      logic                        syncIn_ff,
  output      logic                        syncClkIn_ff,
  output      logic                        twiDataIn_ff,
  output      logic                        twiClkIn_ff,
  output      logic                        timerCapture_ff,
  output      logic [1:0]                  activeUnits_ff,
  output      logic                        latchSix_ff,
  output      logic                        latchSeven_ff,
  output      logic                        latchFifteen_ff
);
  sprs_cfg_if cfg ();

  sprs_regs u_regs (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .regAddr    (regAddr),
    .regWr      (regWr),
    .regRd      (regRd),
    .regWdata   (regWdata),
    .regRdata_ff(regRdata_ff),
    .cfg        (cfg.regs)
  );

  // two-stage synchronisers; stage one is read by stage two only
  logic [11:0] pinMeta_ff;
  logic [11:0] pinSync_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinMeta_ff <= 12'h000;
      pinSync_ff <= 12'h000;
    end else begin
      pinMeta_ff <= {port7Bit2In, port9In, portbIn, port2In};
      pinSync_ff <= pinMeta_ff;
    end
  end
  logic [5:0] p2;
  logic [2:0] pb;
  logic [1:0] p9;
  logic       p72;
  assign p2  = pinSync_ff[5:0];
  assign pb  = pinSync_ff[8:6];
  assign p9  = pinSync_ff[10:9];
  assign p72 = pinSync_ff[11];

  logic asyncOn;
  logic syncOn;
  logic twiOn;
  logic [5:0] nxtP2Out, nxtP2Oe, nxtP2Ser;
  logic [2:0] nxtPbOut, nxtPbOe, nxtPbSer;
  logic [1:0] nxtP9Out, nxtP9Oe;
  logic [1:0] nxtActive;
  logic nxtRx0, nxtRx1, nxtSi, nxtSclk, nxtSda, nxtScl, nxtCap;
  logic nxtL6, nxtL7, nxtL15;
  logic [2:0] grpIn;
  logic [2:0] grpOut, grpOe, grpSer;

  always_comb begin
    asyncOn = 1'b0;
    syncOn  = 1'b0;
    twiOn   = 1'b0;
    case (cfg.pairSel)
      sprs_pkg::PAIR_ASYNC_TWI: begin asyncOn = 1'b1; twiOn  = 1'b1; end
      sprs_pkg::PAIR_ASYNC_SYN: begin asyncOn = 1'b1; syncOn = 1'b1; end
      sprs_pkg::PAIR_SYN_TWI:   begin syncOn  = 1'b1; twiOn  = 1'b1; end
      default: ; // reserved: nothing active, port2 and port B pins stay ports; async one still drives port 9
    endcase
    nxtActive = {twiOn | syncOn, asyncOn | syncOn};
    grpIn  = cfg.groupSel ? pb : p2[2:0];
    grpOut = 3'h0;
    grpOe  = 3'h0;
    grpSer = 3'h0;
    nxtRx0 = 1'b1;
    nxtSi  = 1'b0;
    nxtSclk = 1'b0;
    if (asyncOn) begin
      // first pin transmits, second receives unless swapped
      grpSer = 3'b011;
      if (cfg.swapZero) begin
        grpOut = {2'b00, 1'b0} | {1'b0, txZero, 1'b0};
        grpOe  = 3'b010;
        nxtRx0 = grpIn[0];
      end else begin
        grpOut = {2'b00, txZero};
        grpOe  = 3'b001;
        nxtRx0 = grpIn[1];
      end
    end else if (syncOn) begin
      // pair 10: sync zero in group as out, in, clock
      grpSer  = 3'b111;
      grpOut  = {syncClkOut, 1'b0, syncOut};
      grpOe   = {syncClkOe, 1'b0, 1'b1};
      nxtSi   = grpIn[1];
      nxtSclk = grpIn[2];
    end
    nxtP2Out = 6'h00;
    nxtP2Oe  = 6'h00;
    nxtP2Ser = 6'h00;
    nxtPbOut = 3'h0;
    nxtPbOe  = 3'h0;
    nxtPbSer = 3'h0;
    if (cfg.groupSel) begin
      nxtPbOut = grpOut;
      nxtPbOe  = grpOe;
      nxtPbSer = grpSer;
    end else begin
      nxtP2Out[2:0] = grpOut;
      nxtP2Oe[2:0]  = grpOe;
      nxtP2Ser[2:0] = grpSer;
    end
    nxtSda = 1'b1;
    nxtScl = 1'b1;
    if (twiOn) begin
      nxtP2Ser[4:3] = 2'b11;
      nxtP2Oe[4:3]  = {twiClkOe, twiDataOe}; // open drain: drive low only
      nxtSda = p2[3];
      nxtScl = p2[4];
    end else if (asyncOn && syncOn) begin
      nxtP2Ser[5:3] = 3'b111;
      nxtP2Out[5:3] = {syncClkOut, 1'b0, syncOut};
      nxtP2Oe[5:3]  = {syncClkOe, 1'b0, 1'b1};
      nxtSi   = p2[4];
      nxtSclk = p2[5];
    end
    // async one always on port 9
    nxtP9Out = cfg.swapOne ? {txOne, 1'b0} : {1'b0, txOne};
    nxtP9Oe  = cfg.swapOne ? 2'b10 : 2'b01;
    nxtRx1   = cfg.swapOne ? p9[0] : p9[1];
    case (cfg.timerSel)
      sprs_pkg::TSRC_PORT7:   nxtCap = p72;
      sprs_pkg::TSRC_RX_ZERO: nxtCap = p2[1];
      sprs_pkg::TSRC_RX_ONE:  nxtCap = p9[1];
      default:                nxtCap = 1'b0;
    endcase
    nxtL6  = asyncOn ? rxZeroEvent : (syncOn & syncEvent);
    nxtL7  = asyncOn & txZeroEvent;
    nxtL15 = twiOn ? twiEvent : (syncOn & syncEvent);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      port2Out_ff     <= 6'h00;
      port2Oe_ff      <= 6'h00;
      port2Serial_ff  <= 6'h00;
      portbOut_ff     <= 3'h0;
      portbOe_ff      <= 3'h0;
      portbSerial_ff  <= 3'h0;
      port9Out_ff     <= 2'h0;
      port9Oe_ff      <= 2'h0;
      rxZero_ff       <= 1'b1;
      rxOne_ff        <= 1'b1;
      syncIn_ff       <= 1'b0;
      syncClkIn_ff    <= 1'b0;
      twiDataIn_ff    <= 1'b1;
      twiClkIn_ff     <= 1'b1;
      timerCapture_ff <= 1'b0;
      activeUnits_ff  <= 2'h0;
      latchSix_ff     <= 1'b0;
      latchSeven_ff   <= 1'b0;
      latchFifteen_ff <= 1'b0;
    end else begin
      port2Out_ff     <= nxtP2Out;
      port2Oe_ff      <= nxtP2Oe;
      port2Serial_ff  <= nxtP2Ser;
      portbOut_ff     <= nxtPbOut;
      portbOe_ff      <= nxtPbOe;
      portbSerial_ff  <= nxtPbSer;
      port9Out_ff     <= nxtP9Out;
      port9Oe_ff      <= nxtP9Oe;
      rxZero_ff       <= nxtRx0;
      rxOne_ff        <= nxtRx1;
      syncIn_ff       <= nxtSi;
      syncClkIn_ff    <= nxtSclk;
      twiDataIn_ff    <= nxtSda;
      twiClkIn_ff     <= nxtScl;
      timerCapture_ff <= nxtCap;
      activeUnits_ff  <= nxtActive;
      latchSix_ff     <= nxtL6;
      latchSeven_ff   <= nxtL7;
      latchFifteen_ff <= nxtL15;
    end
  end

  a_reserved_idle : assert property (@(posedge clk) disable iff (sys_rst)
    cfg.pairSel == 2'h3 |=> port2Serial_ff == 6'h00 && portbSerial_ff == 3'h0)
    else $error("reserved pair claimed pins");
  a_twi_pins : assert property (@(posedge clk) disable iff (sys_rst)
    cfg.pairSel != 2'h1 && cfg.pairSel != 2'h3 |=> port2Serial_ff[4:3] == 2'b11)
    else $error("two-wire pins not claimed");
  a_group_place : assert property (@(posedge clk) disable iff (sys_rst)
    cfg.groupSel && cfg.pairSel != 2'h3 |=> port2Serial_ff[2:0] == 3'h0 && portbSerial_ff != 3'h0)
    else $error("group select misplaced");
  a_swap_one : assert property (@(posedge clk) disable iff (sys_rst)
    cfg.swapOne |=> port9Oe_ff == 2'b10)
    else $error("async one swap wrong");
  a_swap_zero : assert property (@(posedge clk) disable iff (sys_rst)
    cfg.pairSel[1] == 1'b0 && !cfg.swapZero && !cfg.groupSel |=> port2Oe_ff[1:0] == 2'b01)
    else $error("async zero pins wrong");
  a_latch_seven : assert property (@(posedge clk) disable iff (sys_rst)
    cfg.pairSel == 2'h2 |=> !latchSeven_ff)
    else $error("latch seven active in pair 10");
  a_latch_fifteen : assert property (@(posedge clk) disable iff (sys_rst)
    cfg.pairSel == 2'h1 && syncEvent |=> latchFifteen_ff)
    else $error("sync event missing on latch fifteen");
  a_timer_src : assert property (@(posedge clk) disable iff (sys_rst)
    cfg.timerSel == 2'h2 |=> timerCapture_ff == $past(p9[1]))
    else $error("timer capture source wrong");
  a_two_units : assert property (@(posedge clk) disable iff (sys_rst)
    cfg.pairSel != 2'h3 |=> activeUnits_ff == 2'b11)
    else $error("pair does not enable two units");
  c_pair_sync : cover property (@(posedge clk) cfg.pairSel == 2'h1 && cfg.groupSel);
  c_pair_twi : cover property (@(posedge clk) cfg.pairSel == 2'h2);
  c_swapped : cover property (@(posedge clk) cfg.swapZero && cfg.swapOne);
endmodule : serial_pin_route_select

/* File: verilog/sprs_cfg_if.sv */
// sprs_cfg_if: decoded routing settings passed from register file to router
// assumes one clock domain; carries levels only
`timescale 1ns/10ps
interface sprs_cfg_if;
  logic [1:0] timerSel;
  logic       groupSel;
  logic [1:0] pairSel;
  logic       swapOne;
  logic       swapZero;
  modport regs  (output timerSel, output groupSel, output pairSel, output swapOne, output swapZero);
  modport route (input timerSel, input groupSel, input pairSel, input swapOne, input swapZero);
endinterface : sprs_cfg_if

/* File: verilog/sprs_pkg.sv */
// sprs_pkg: constants for the serial pin route select block
// assumes an 8-bit memory-mapped register port with 12-bit byte addresses
package sprs_pkg;
  localparam int         ADDR_W          = 12;
  localparam logic [11:0] SWAP_OFFSET    = 12'hF57;
  localparam logic [11:0] ROUTE_OFFSET   = 12'hFCB;
  localparam logic [7:0]  SWAP_RESET     = 8'h00;
  localparam logic [7:0]  ROUTE_RESET    = 8'h00;
  localparam logic [7:0]  SWAP_MASK      = 8'h03;
  localparam logic [7:0]  ROUTE_MASK     = 8'hD3;
  localparam int          TIMER_SEL_LSB  = 6;
  localparam int          GROUP_SEL_BIT  = 4;
  localparam int          PAIR_SEL_LSB   = 0;
  localparam int          SWAP_ONE_BIT   = 1;
  localparam int          SWAP_ZERO_BIT  = 0;
  localparam logic [1:0]  PAIR_ASYNC_TWI = 2'h0;
  localparam logic [1:0]  PAIR_ASYNC_SYN = 2'h1;
  localparam logic [1:0]  PAIR_SYN_TWI   = 2'h2;
  localparam logic [1:0]  TSRC_PORT7     = 2'h0;
  localparam logic [1:0]  TSRC_RX_ZERO   = 2'h1;
  localparam logic [1:0]  TSRC_RX_ONE    = 2'h2;
endpackage : sprs_pkg

/* File: verilog/sprs_regs.sv */
// sprs_regs: the two routing control registers on the byte register port
// assumes single-cycle write strobe and registered read data
`timescale 1ns/10ps
module sprs_regs (
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire logic [sprs_pkg::ADDR_W-1:0]    regAddr,
  input  wire logic                           regWr,
  input  wire logic                           regRd,
  input  wire logic [7:0]                     regWdata,
  output      logic [7:0]                     regRdata_ff,
  sprs_cfg_if.regs                            cfg
);
  logic [7:0] swap_ff;
  logic [7:0] route_ff;
  logic [7:0] nxt_swap;
  logic [7:0] nxt_route;
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_swap  = swap_ff;
    nxt_route = route_ff;
    nxt_rdata = regRdata_ff;
    // unused bits are masked so they never store a value
    if (regWr && regAddr == sprs_pkg::SWAP_OFFSET) nxt_swap = regWdata & sprs_pkg::SWAP_MASK;
    if (regWr && regAddr == sprs_pkg::ROUTE_OFFSET) nxt_route = regWdata & sprs_pkg::ROUTE_MASK;
    if (regRd) begin
      if (regAddr == sprs_pkg::SWAP_OFFSET) nxt_rdata = swap_ff;
      else if (regAddr == sprs_pkg::ROUTE_OFFSET) nxt_rdata = route_ff;
      else nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      swap_ff     <= sprs_pkg::SWAP_RESET;
      route_ff    <= sprs_pkg::ROUTE_RESET;
      regRdata_ff <= 8'h00;
    end else begin
      swap_ff     <= nxt_swap;
      route_ff    <= nxt_route;
      regRdata_ff <= nxt_rdata;
    end
  end

  assign cfg.timerSel = route_ff[sprs_pkg::TIMER_SEL_LSB +: 2];
  assign cfg.groupSel = route_ff[sprs_pkg::GROUP_SEL_BIT];
  assign cfg.pairSel  = route_ff[sprs_pkg::PAIR_SEL_LSB +: 2];
  assign cfg.swapOne  = swap_ff[sprs_pkg::SWAP_ONE_BIT];
  assign cfg.swapZero = swap_ff[sprs_pkg::SWAP_ZERO_BIT];

  a_unused_zero : assert property (@(posedge clk) disable iff (sys_rst)
    (route_ff & ~sprs_pkg::ROUTE_MASK) == 8'h00 && (swap_ff & ~sprs_pkg::SWAP_MASK) == 8'h00)
    else $error("unused register bits not zero");
  a_write_lands : assert property (@(posedge clk) disable iff (sys_rst)
    regWr && regAddr == sprs_pkg::ROUTE_OFFSET |=> route_ff == ($past(regWdata) & sprs_pkg::ROUTE_MASK))
    else $error("route register write lost");
endmodule : sprs_regs
